// ### common/bidao_pkg.sv
// shared constants and types for the bit, invert and decimal-adjust datapath
// ---------------------------------------------------------------------------
// What this block does
// - bit clear zeroes one bit, flags untouched
// - watchdog kick restarts count, clears expiry, powerdown
// - invert memory complements byte in place
// - invert to working loads complement, memory kept
// - inverts update null flag only
// - low nibble over 9 or half-carry adds 6
// - high nibble over 9 or overflow adds 6
// - adjustment adds exactly 00H, 06H, 60H or 66H
// - decimal adjust result goes to memory
// - decimal adjust touches only overflow-out flag
// ---------------------------------------------------------------------------
package bidao_pkg;

  // ---------------------------------------------------------------------------
  // bus geometry and register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          MEM_DEPTH    = 16;
  localparam int          MEM_AW       = 4;
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_WORK     = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_WDCOUNT  = 8'h0C;
  localparam logic [7:0]  OFF_MEM_BASE = 8'h40;
  localparam logic [1:0]  MEM_SEL      = 2'h1;

  // ---------------------------------------------------------------------------
  // command register fields
  // ---------------------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BIT_LSB  = 4;
  localparam int CMD_ADDR_LSB = 8;

  // ---------------------------------------------------------------------------
  // status register bit positions
  // ---------------------------------------------------------------------------
  localparam int ST_ZERO     = 0;
  localparam int ST_HALF     = 1;
  localparam int ST_OVF      = 2;
  localparam int ST_EXPIRY   = 3;
  localparam int ST_PDOWN    = 4;
  localparam int ST_W        = 5;
  localparam logic [4:0] STATUS_RST = 5'h00;

  // ---------------------------------------------------------------------------
  // decimal adjust constants
  // ---------------------------------------------------------------------------
  localparam logic [3:0] NIB_MAX  = 4'h9;
  localparam logic [7:0] ADJ_NONE = 8'h00;
  localparam logic [7:0] ADJ_LOW  = 8'h06;
  localparam logic [7:0] ADJ_HIGH = 8'h60;
  localparam logic [7:0] ADJ_BOTH = 8'h66;

  // ---------------------------------------------------------------------------
  // watchdog default limit and reset values
  // ---------------------------------------------------------------------------
  localparam int          WD_W       = 16;
  localparam logic [15:0] WD_LIMIT   = 16'hFFFF;
  localparam logic [7:0]  WORK_RST   = 8'h00;
  localparam logic [7:0]  MEM_RST    = 8'h00;

  // ---------------------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_BIT_CLEAR   = 4'h1,
    OP_WD_KICK     = 4'h2,
    OP_INV_MEM     = 4'h3,
    OP_INV_WORK    = 4'h4,
    OP_DEC_ADJUST  = 4'h5
  } bidao_op_e;

  // command word as written by software; field order follows the CMD_*_LSB positions
  typedef struct packed {
    logic [MEM_AW-1:0] memAddr;
    logic              pad;
    logic [2:0]        bitIdx;
    logic [3:0]        opcode;
  } bidao_cmd_s;

  // status flags grouped
  typedef struct packed {
    logic powerdownFlag;
    logic watchdogExpiryFlag;
    logic overflowFlag;
    logic halfCarryFlag;
    logic zeroFlag;
  } bidao_flags_s;

endpackage : bidao_pkg

// ### rtl/bidao_core.sv
// bit clear, watchdog kick, invert and decimal adjust datapath with bus slave
`timescale 1ns/10ps
module bidao_core
  import bidao_pkg::*;
#(
  parameter logic [WD_W-1:0] WD_LIMIT_P = WD_LIMIT
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest
);

  // ---------------------------------------------------------------------------
  // reset release synchroniser
  // ---------------------------------------------------------------------------
  logic [1:0] rstPipe;
  logic       rstN;

  // async assert, release after two edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstN = rstPipe[1];

  // ---------------------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------------------
  logic [7:0]        dataMem      [MEM_DEPTH];
  logic [7:0]        next_dataMem [MEM_DEPTH];
  logic [7:0]        workingRegister;
  logic [7:0]        next_workingRegister;
  bidao_flags_s      flags;
  bidao_flags_s      next_flags;
  logic [WD_W-1:0]   watchdogTimer;
  logic [WD_W-1:0]   next_watchdogTimer;
  bidao_cmd_s        lastCmd;
  bidao_cmd_s        next_lastCmd;
  logic              busWait;
  logic              next_busWait;
  logic [DATA_W-1:0] readData;
  logic [DATA_W-1:0] next_readData;

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic              busReq;
  logic              busDone;
  logic              memHit;
  logic [MEM_AW-1:0] busMemIdx;
  bidao_cmd_s        wrCmd;

  // one wait state: request taken while busWait is high, completes next edge
  assign busReq    = avs_read | avs_write;
  assign busDone   = busReq & ~busWait;
  assign memHit    = (avs_address[7:6] == MEM_SEL);
  assign busMemIdx = avs_address[MEM_AW+1:2];
  assign wrCmd     = bidao_cmd_s'(avs_writedata[$bits(bidao_cmd_s)-1:0]);

  // ---------------------------------------------------------------------------
  // operand fetch and decimal adjust arithmetic
  // ---------------------------------------------------------------------------
  logic [7:0] operand;
  logic [7:0] inverted;
  logic [7:0] lowFixed;
  logic [7:0] adjConst;
  logic [7:0] adjusted;
  logic       addLow;
  logic       addHigh;

  // operand is the byte named by the command being written
  assign operand  = dataMem[wrCmd.memAddr];
  assign inverted = ~operand;

  // adjust constant; high test sees the original nibble and the nibble after
  // the low fix, so a carry out of the low nibble is not missed
  always_comb begin
    addLow   = (workingRegister[3:0] > NIB_MAX) | flags.halfCarryFlag;
    lowFixed = addLow ? workingRegister + ADJ_LOW : workingRegister;
    addHigh  = (workingRegister[7:4] > NIB_MAX) | (lowFixed[7:4] > NIB_MAX)
             | flags.overflowFlag;
    unique case ({addHigh, addLow})
      2'b00:   adjConst = ADJ_NONE;
      2'b01:   adjConst = ADJ_LOW;
      2'b10:   adjConst = ADJ_HIGH;
      default: adjConst = ADJ_BOTH;
    endcase
    adjusted = workingRegister + adjConst;
  end

  // ---------------------------------------------------------------------------
  // next state of memory, working register, flags and watchdog
  // ---------------------------------------------------------------------------
  always_comb begin
    next_dataMem         = dataMem;
    next_workingRegister = workingRegister;
    next_flags           = flags;
    next_lastCmd         = lastCmd;
    next_watchdogTimer   = watchdogTimer;

    // free-running watchdog; reaching the limit raises the expiry flag
    if (watchdogTimer == WD_LIMIT_P) begin
      next_watchdogTimer       = '0;
      next_flags.watchdogExpiryFlag = 1'b1;
    end else begin
      next_watchdogTimer = watchdogTimer + 1'b1;
    end

    if (busDone && avs_write) begin
      if (memHit) begin
        next_dataMem[busMemIdx] = avs_writedata[7:0];
      end else begin
        unique case (avs_address)
          OFF_WORK: begin
            next_workingRegister = avs_writedata[7:0];
          end
          OFF_STATUS: begin
            // a limit hit in the same cycle still sets expiry: set beats clear
            next_flags                    = bidao_flags_s'(avs_writedata[ST_W-1:0]);
            next_flags.watchdogExpiryFlag = avs_writedata[ST_EXPIRY] | (watchdogTimer == WD_LIMIT_P);
          end
          OFF_CMD: begin
            next_lastCmd = wrCmd;
            unique case (wrCmd.opcode)
              OP_BIT_CLEAR: begin
                // flags left alone
                next_dataMem[wrCmd.memAddr][wrCmd.bitIdx] = 1'b0;
              end
              OP_WD_KICK: begin
                // kick restarts the count, so no expiry can land this cycle
                next_watchdogTimer            = '0;
                next_flags.watchdogExpiryFlag = 1'b0;
                next_flags.powerdownFlag      = 1'b0;
              end
              OP_INV_MEM: begin
                next_dataMem[wrCmd.memAddr] = inverted;
                next_flags.zeroFlag         = (inverted == 8'h00);
              end
              OP_INV_WORK: begin
                next_workingRegister = inverted;
                next_flags.zeroFlag  = (inverted == 8'h00);
              end
              OP_DEC_ADJUST: begin
                next_dataMem[wrCmd.memAddr] = adjusted;
                next_flags.overflowFlag     = addHigh;
              end
              default: begin
                next_lastCmd = wrCmd;
              end
            endcase
          end
          default: begin
            next_lastCmd = lastCmd;
          end
        endcase
      end
    end
  end

  // register the datapath state
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        dataMem[i] <= MEM_RST;
      end
      workingRegister <= WORK_RST;
      flags           <= bidao_flags_s'(STATUS_RST);
      watchdogTimer   <= '0;
      lastCmd         <= '0;
    end else begin
      dataMem         <= next_dataMem;
      workingRegister <= next_workingRegister;
      flags           <= next_flags;
      watchdogTimer   <= next_watchdogTimer;
      lastCmd         <= next_lastCmd;
    end
  end

  // ---------------------------------------------------------------------------
  // bus handshake and read data
  // ---------------------------------------------------------------------------
  always_comb begin
    next_busWait  = 1'b1;
    next_readData = readData;
    if (busReq && busWait) begin
      next_busWait  = 1'b0;
      next_readData = '0;
      // unmapped addresses read as zero
      if (memHit) begin
        next_readData[7:0] = dataMem[busMemIdx];
      end else begin
        unique case (avs_address)
          OFF_CMD:     next_readData[$bits(bidao_cmd_s)-1:0] = lastCmd;
          OFF_WORK:    next_readData[7:0]      = workingRegister;
          OFF_STATUS:  next_readData[ST_W-1:0] = flags;
          OFF_WDCOUNT: next_readData[WD_W-1:0] = watchdogTimer;
          default:     next_readData           = '0;
        endcase
      end
    end
  end

  // waitrequest resets high so no access completes during reset
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busWait  <= 1'b1;
      readData <= '0;
    end else begin
      busWait  <= next_busWait;
      readData <= next_readData;
    end
  end

  assign avs_waitrequest = busWait;
  assign avs_readdata    = readData;

endmodule : bidao_core

// ### verif/bidao_core_assertions.sv
// bus handshake and read-data shape checks for the datapath block
`timescale 1ns/10ps
module bidao_core_assertions
  import bidao_pkg::*;
#(
  parameter logic [WD_W-1:0] WD_LIMIT_P = WD_LIMIT
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // read completing at this edge
  logic rdDone;
  assign rdDone = avs_read && !avs_waitrequest;

  ack_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge held longer than one cycle");
  one_wait_a: assert property (avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
    else $error("taken request not answered after one wait state");
  idle_no_ack_a: assert property (avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("acknowledge without a request");
  data_hold_a: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved outside an answer");
  status_width_a: assert property (rdDone && avs_address == OFF_STATUS |-> avs_readdata[31:ST_W] == '0)
    else $error("status read carries bits above the flags");
  mem_width_a: assert property (rdDone && avs_address[7:6] == MEM_SEL |-> avs_readdata[31:8] == '0)
    else $error("memory read wider than a byte");
  wd_range_a: assert property (rdDone && avs_address == OFF_WDCOUNT |-> avs_readdata <= 32'(WD_LIMIT_P))
    else $error("watchdog count beyond its limit");
  unmapped_zero_a: assert property (rdDone && avs_address inside {[8'h10:8'h3C]} |-> avs_readdata == '0)
    else $error("unmapped read not zero");

  // main scenarios reached
  cover property (avs_write && !avs_waitrequest && avs_address == OFF_CMD);
  cover property (rdDone && avs_address[7:6] == MEM_SEL);
  cover property (rdDone && avs_address == OFF_STATUS);
endmodule : bidao_core_assertions

// ### verif/bidao_core_tb_top.sv
// self-checking bench for the bit, invert and decimal-adjust datapath
`timescale 1ns/10ps
module bidao_core_tb_top;
  import bidao_pkg::*;
  // short watchdog limit keeps the expiry test brief
  localparam logic [15:0] WDL = 16'h0020;
  logic              clk;
  logic              rst_b;
  logic              avs_read;
  logic              avs_write;
  logic              avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata;
  logic [DATA_W-1:0] avs_readdata;
  logic [DATA_W-1:0] rd;
  int                err_total;
  int                checks_done;

  bidao_core #(.WD_LIMIT_P(WDL)) DUT (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ----------------------------------------
  // bus tasks and compare
  // ----------------------------------------
  // request held until waitrequest is seen low at an edge
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bw

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // read data taken at the completing edge, masked before compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    chk(rd & m, exp);
  endtask : rchk

  function automatic logic [7:0] ma(input logic [3:0] a);
    return OFF_MEM_BASE + {2'b00, a, 2'b00};
  endfunction : ma

  task automatic op(input logic [3:0] o, input logic [2:0] b, input logic [3:0] a);
    bw(OFF_CMD, {20'h0, a, 1'b0, b, o});
  endtask : op

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_bitclr();
    logic [7:0] e;
    bw(ma(3), 32'h0000_00FF);
    bw(OFF_STATUS, 32'h0000_0017);
    for (int i = 0; i < 8; i++) begin
      e = 8'hFF << (i + 1);
      op(OP_BIT_CLEAR, 3'(i), 4'h3);
      rchk(ma(3), {24'h0, e}, 32'hFFFF_FFFF);
    end
    rchk(OFF_STATUS, 32'h0000_0017, 32'h0000_0017);
  endtask : t_bitclr

  task automatic t_kick();
    bw(OFF_STATUS, 32'h0000_001F);
    op(OP_WD_KICK, 3'h0, 4'h0);
    rchk(OFF_STATUS, 32'h0000_0007, 32'h0000_001F);
    rchk(OFF_WDCOUNT, 32'h0, 32'hFFFF_FFF8);
    repeat (40) @(posedge clk);
    rchk(OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
    op(OP_WD_KICK, 3'h0, 4'h0);
    rchk(OFF_STATUS, 32'h0, 32'h0000_0018);
  endtask : t_kick

  // unknown opcode is only recorded; memory and working register keep their values
  task automatic t_unknown();
    bw(ma(2), 32'h0000_00A5);
    bw(OFF_WORK, 32'h0000_003C);
    op(4'hF, 3'h5, 4'h2);
    rchk(OFF_CMD, 32'h0000_025F, 32'hFFFF_FFFF);
    rchk(ma(2), 32'h0000_00A5, 32'hFFFF_FFFF);
    rchk(OFF_WORK, 32'h0000_003C, 32'hFFFF_FFFF);
  endtask : t_unknown

  // expiry bit masked: the short watchdog may fire meanwhile
  task automatic t_inv();
    bw(ma(5), 32'h0000_00FF);
    bw(OFF_STATUS, 32'h0000_0016);
    op(OP_INV_MEM, 3'h0, 4'h5);
    rchk(ma(5), 32'h0, 32'hFFFF_FFFF);
    rchk(OFF_STATUS, 32'h0000_0017, 32'h0000_0017);
    op(OP_INV_MEM, 3'h0, 4'h5);
    rchk(ma(5), 32'h0000_00FF, 32'hFFFF_FFFF);
    rchk(OFF_STATUS, 32'h0000_0016, 32'h0000_0017);
    bw(ma(6), 32'h0000_00A5);
    bw(OFF_WORK, 32'h0);
    bw(OFF_STATUS, 32'h0000_0007);
    op(OP_INV_WORK, 3'h0, 4'h6);
    rchk(OFF_WORK, 32'h0000_005A, 32'hFFFF_FFFF);
    rchk(ma(6), 32'h0000_00A5, 32'hFFFF_FFFF);
    rchk(OFF_STATUS, 32'h0000_0006, 32'h0000_0017);
  endtask : t_inv

  task automatic t_daa();
    logic [7:0] acc [8] = '{8'h00, 8'h0A, 8'h12, 8'hA0, 8'h00, 8'h9A, 8'h99, 8'hFF};
    logic [1:0] fl [8]  = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h0};
    // adjusted bytes and overflow-out worked out by hand from the nibble tests
    logic [7:0] res [8] = '{8'h00, 8'h10, 8'h18, 8'h00, 8'h60, 8'h00, 8'hFF, 8'h65};
    logic       hi [8]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 8; i++) begin
      bw(OFF_WORK, {24'h0, acc[i]});
      bw(OFF_STATUS, {29'h0, fl[i], 1'b1});
      op(OP_DEC_ADJUST, 3'h0, 4'h7);
      rchk(ma(7), {24'h0, res[i]}, 32'hFFFF_FFFF);
      rchk(OFF_WORK, {24'h0, acc[i]}, 32'hFFFF_FFFF);
      rchk(OFF_STATUS, {29'h0, hi[i], fl[i][0], 1'b1}, 32'h0000_0017);
    end
  endtask : t_daa

  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // clock, reset, sequence and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    err_total = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(OFF_STATUS, 32'h0, 32'hFFFF_FFFF);
    rchk(OFF_WORK, 32'h0, 32'hFFFF_FFFF);
    rchk(8'h20, 32'h0, 32'hFFFF_FFFF);
    t_bitclr();
    t_kick();
    t_unknown();
    t_inv();
    t_daa();
    end_sim();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : bidao_core_tb_top

bind bidao_core bidao_core_assertions #(.WD_LIMIT_P(WD_LIMIT_P)) chk_i (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
